//--- rtl/hbd_params.svh
// Constants of the host bus and DMA port: addresses, directions, reset values.
// Assumes inclusion from the package, the port module or the bench only.
`ifndef HBD_PARAMS_SVH
`define HBD_PARAMS_SVH

// Address of the 16-bit DMA buffer register
`define HBD_DMA_BUF_ADDR 7'h40
// Direction bit value meaning device to host
`define HBD_DIR_TO_HOST 1'b1
// Byte order select value putting the first byte on bits 15:8
`define HBD_ORDER_FIRST_HIGH 1'b1
// Reset level of idle active-low pins, then zero byte, word and address values
`define HBD_PIN_IDLE_N 1'b1
`define HBD_BYTE_ZERO 8'h00
`define HBD_WORD_ZERO 16'h0000
`define HBD_ADDR_ZERO 7'h00

`endif

//--- rtl/hbd_pkg.sv
// Types of the host bus and DMA port: pin bundle, access and word carriers, states.
// Assumes the constants header sits beside it.
`include "hbd_params.svh"

package hbd_pkg;

  // Host pins sampled together through one synchroniser
  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] data;
    logic chipSelectN;
    logic dataStrobeN;
    logic readWriteN;
    logic byteOrderSelect;
    logic testOutputEnable;
    logic dmaAcknowledgeN;
    logic portServiceAcknowledgeN;
    logic daisyGrantN;
  } hbd_pins_s;

  // One register access handed to the core
  typedef struct packed {
    logic write;
    logic read;
    logic service_acknowledge_n;
    logic dma_buffer_register;
    logic [6:0] addr;
    logic [15:0] word;
  } hbd_access_s;

  // One DMA word in parallel-port order
  typedef struct packed {
    logic valid;
    logic [7:0] first;
    logic [7:0] second;
  } hbd_dma_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_LATCH,
    ST_ACK,
    ST_RELEASE
  } hbd_state_e;

endpackage

//--- rtl/hbd_host_port.sv
// Host bus interface and slave DMA handshake of a parallel port controller.
// Assumes the core answers a read strobe with regReadData on the next edge.
`timescale 1ns/1ps
`include "hbd_params.svh"

// Overview of operation
// - Byte order select high puts first byte on 15:8, low on 7:0.
// - Byte ordering applies only to DMA words and DMA buffer writes.
// - Output a half-rate clock at half the frequency of the internal operating clock.
// - Register cycle starts only with strobe low and either chip select low or service grant and acknowledge low.
// - Address with select or service grant and strobe picks one register.
// - Ordinary register writes store only data bits 7:0.
// - DMA and DMA buffer writes move all sixteen bits at once.
// - Register reads drive the byte on both halves of the bus.
// - Strobe latches write data or enables read data in a cycle.
// - Strobe and read/write are ignored during DMA transfers.
// - Acknowledge is asserted once the requested operation is complete.
// - Acknowledge ends by driving high, then releasing to high impedance.
// - Acknowledge is never asserted during DMA cycles.
// - Test output enable low holds every driving pin tristate.
// - Reset returns all registers and transfers to default state.
// - With DMA enabled, request goes low when the FIFO wants it.
// - Stopping DMA drops the request at the acknowledge falling edge.
// - DMA acknowledge is the only handshake during a DMA transfer.
// - DMA direction follows the internal direction control bit.
// - Service acknowledge needs daisy grant, strobe and port service acknowledge.
module hbd_host_port (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Host bus pins
  input wire logic [6:0] hostAddress,
  input wire logic [15:0] hostDataIn,
  output logic [15:0] hostDataOut,
  output logic hostDataOe,
  input wire logic chipSelectN,
  input wire logic dataStrobeN,
  input wire logic readWriteN,
  input wire logic byteOrderSelect,
  input wire logic testOutputEnable,
  output logic transferAckOut,
  output logic transferAckOe,
  output logic clockHalf,
  output logic clockHalfOe,
  // DMA and service pins
  output logic dmaRequestOut,
  output logic dmaRequestOe,
  input wire logic dmaAcknowledgeN,
  input wire logic portServiceAcknowledgeN,
  input wire logic daisyGrantN,
  // Core register side
  output hbd_pkg::hbd_access_s access,
  input wire logic [7:0] regReadData,
  // Core DMA side
  input wire logic dmaEnableBit,
  input wire logic dmaDirectionBit,
  input wire logic fifoWantsDma,
  input wire logic dmaStopAfter,
  input wire logic [7:0] dmaFirstByte,
  input wire logic [7:0] dmaSecondByte,
  output hbd_pkg::hbd_dma_s dmaWord,
  output logic dmaWordTaken
);

  // First byte on 15:8 when order is high
  function automatic logic [15:0] orderWord(input logic order, input logic [7:0] first,
                                           input logic [7:0] second);
    orderWord = (order == `HBD_ORDER_FIRST_HIGH) ? {first, second} : {second, first};
  endfunction

  hbd_pkg::hbd_pins_s pinsMeta_reg, pins_reg;
  hbd_pkg::hbd_pins_s pinsIn;
  hbd_pkg::hbd_state_e state_reg, state_next;
  hbd_pkg::hbd_access_s access_reg, access_next;
  hbd_pkg::hbd_dma_s dmaWord_reg, dmaWord_next;
  logic dmaAckPrev_reg, dmaStopped_reg, dmaStopped_next;
  logic [15:0] dmaCapture_reg;
  logic [15:0] dataOut_reg, dataOut_next;
  logic dataOe_reg, dataOe_next;
  logic ackOut_reg, ackOut_next, ackOe_reg, ackOe_next;
  logic reqOut_reg, reqOut_next, reqOe_reg;
  logic half_reg, halfOe_reg, taken_reg;
  logic readCycle_reg, readCycle_next;

  assign pinsIn = '{addr: hostAddress, data: hostDataIn, chipSelectN: chipSelectN,
                    dataStrobeN: dataStrobeN, readWriteN: readWriteN,
                    byteOrderSelect: byteOrderSelect, testOutputEnable: testOutputEnable,
                    dmaAcknowledgeN: dmaAcknowledgeN,
                    portServiceAcknowledgeN: portServiceAcknowledgeN,
                    daisyGrantN: daisyGrantN};

  // Two-stage synchroniser on every pin input
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pinsMeta_reg <= '1;
      pins_reg <= '1;
    end else begin
      pinsMeta_reg <= pinsIn;
      pins_reg <= pinsMeta_reg;
    end
  end

  // Decoding of the synchronised pins
  wire dmaActive = !pins_reg.dmaAcknowledgeN;
  wire dmaAckFall = dmaActive && dmaAckPrev_reg;
  wire dmaAckRise = !dmaActive && !dmaAckPrev_reg;
  wire toHost = (dmaDirectionBit == `HBD_DIR_TO_HOST);
  wire test_output_enable = pins_reg.testOutputEnable;
  wire strobe = !pins_reg.dataStrobeN;
  // Select ignored while DMA runs, so a stray strobe cannot start a cycle
  wire ioSelect = !dmaActive && strobe && !pins_reg.chipSelectN;
  wire svcSelect = !dmaActive && strobe && !pins_reg.daisyGrantN &&
                   !pins_reg.portServiceAcknowledgeN;
  wire isDmaBuf = (pins_reg.addr == `HBD_DMA_BUF_ADDR);
  wire isRead = ioSelect && pins_reg.readWriteN;
  wire [15:0] busWrite = isDmaBuf ? pins_reg.data : {`HBD_BYTE_ZERO, pins_reg.data[7:0]};
  wire [15:0] dmaBusOut = orderWord(pins_reg.byteOrderSelect, dmaFirstByte,
                                    dmaSecondByte);
  wire order = pins_reg.byteOrderSelect;
  wire [7:0] rxFirst = (order == `HBD_ORDER_FIRST_HIGH) ? dmaCapture_reg[15:8]
                                                       : dmaCapture_reg[7:0];
  wire [7:0] rxSecond = (order == `HBD_ORDER_FIRST_HIGH) ? dmaCapture_reg[7:0]
                                                        : dmaCapture_reg[15:8];

  // Register cycle sequencing
  always_comb begin
    state_next = state_reg;
    access_next = '0;
    access_next.addr = pins_reg.addr;
    readCycle_next = readCycle_reg;
    ackOut_next = ackOut_reg;
    ackOe_next = ackOe_reg;
    dataOut_next = dataOut_reg;
    dataOe_next = 1'b0;
    case (state_reg)
      hbd_pkg::ST_IDLE: begin
        ackOe_next = 1'b0;
        ackOut_next = `HBD_PIN_IDLE_N;
        if (ioSelect || svcSelect) begin
          state_next = hbd_pkg::ST_ACCESS;
        end
      end
      hbd_pkg::ST_ACCESS: begin
        readCycle_next = isRead || svcSelect;
        if (svcSelect) begin
          access_next.service_acknowledge_n = 1'b1;
        end else if (isRead) begin
          access_next.read = 1'b1;
        end else if (ioSelect) begin
          access_next.write = 1'b1;
          access_next.dma_buffer_register = isDmaBuf;
          access_next.word = isDmaBuf ? orderWord(order, busWrite[15:8],
                                                  busWrite[7:0]) : busWrite;
        end
        state_next = (ioSelect || svcSelect) ? hbd_pkg::ST_LATCH : hbd_pkg::ST_IDLE;
      end
      hbd_pkg::ST_LATCH: begin
        dataOut_next = {regReadData, regReadData};
        state_next = hbd_pkg::ST_ACK;
      end
      hbd_pkg::ST_ACK: begin
        dataOe_next = readCycle_reg && strobe;
        ackOut_next = 1'b0;
        ackOe_next = 1'b1;
        if (!strobe) begin
          ackOut_next = `HBD_PIN_IDLE_N;
          state_next = hbd_pkg::ST_RELEASE;
        end
      end
      hbd_pkg::ST_RELEASE: begin
        ackOe_next = 1'b0;
        state_next = hbd_pkg::ST_IDLE;
      end
      default: begin
        state_next = hbd_pkg::ST_IDLE;
      end
    endcase
    if (dmaActive) begin
      dataOut_next = dmaBusOut;
      dataOe_next = toHost;
    end
  end

  // DMA word handling and request
  always_comb begin
    dmaWord_next = '0;
    dmaStopped_next = dmaStopped_reg;
    if (dmaAckRise && !toHost) begin
      dmaWord_next = '{valid: 1'b1, first: rxFirst, second: rxSecond};
    end
    if (dmaAckFall && dmaStopAfter) begin
      dmaStopped_next = 1'b1;
    end else if (!dmaActive && !dmaAckFall) begin
      dmaStopped_next = 1'b0;
    end
    reqOut_next = !(dmaEnableBit && fifoWantsDma && !dmaStopped_next);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= hbd_pkg::ST_IDLE;
      access_reg <= '0;
      readCycle_reg <= 1'b0;
      dataOut_reg <= `HBD_WORD_ZERO;
      dataOe_reg <= 1'b0;
      ackOut_reg <= `HBD_PIN_IDLE_N;
      ackOe_reg <= 1'b0;
      dmaWord_reg <= '0;
      dmaCapture_reg <= `HBD_WORD_ZERO;
      dmaAckPrev_reg <= 1'b1;
      dmaStopped_reg <= 1'b0;
      reqOut_reg <= `HBD_PIN_IDLE_N;
      reqOe_reg <= 1'b0;
      taken_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      access_reg <= access_next;
      readCycle_reg <= readCycle_next;
      dataOut_reg <= dataOut_next;
      dataOe_reg <= dataOe_next && test_output_enable;
      ackOut_reg <= ackOut_next || dmaActive;
      ackOe_reg <= ackOe_next && test_output_enable;
      dmaWord_reg <= dmaWord_next;
      dmaCapture_reg <= dmaActive ? pins_reg.data : dmaCapture_reg;
      dmaAckPrev_reg <= !dmaActive;
      dmaStopped_reg <= dmaStopped_next;
      reqOut_reg <= reqOut_next;
      reqOe_reg <= test_output_enable;
      taken_reg <= dmaAckRise && toHost;
    end
  end

  // Half-rate clock; registers on the core side run from the same source
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      half_reg <= 1'b0;
      halfOe_reg <= 1'b0;
    end else begin
      half_reg <= !half_reg;
      halfOe_reg <= test_output_enable;
    end
  end

  assign hostDataOut = dataOut_reg;
  assign hostDataOe = dataOe_reg;
  assign transferAckOut = ackOut_reg;
  assign transferAckOe = ackOe_reg;
  assign clockHalf = half_reg;
  assign clockHalfOe = halfOe_reg;
  assign dmaRequestOut = reqOut_reg;
  assign dmaRequestOe = reqOe_reg;
  assign access = access_reg;
  assign dmaWord = dmaWord_reg;
  assign dmaWordTaken = taken_reg;

  // Checks
  sequence seqAckHeld;
    ackOe_reg && !ackOut_reg;
  endsequence
  sequence seqAckDriveHigh;
    ackOe_reg && ackOut_reg ##1 !ackOe_reg;
  endsequence

  AST_BYTE_ORDER: assert property (@(posedge clock) disable iff (!resetn)
    $past(dmaActive) && $past(toHost) |->
      hostDataOut == $past(orderWord(order, dmaFirstByte, dmaSecondByte)))
    else $error("DMA word byte order wrong");
  AST_READ_DUP: assert property (@(posedge clock) disable iff (!resetn)
    hostDataOe && !$past(dmaActive) |-> hostDataOut[15:8] == hostDataOut[7:0])
    else $error("Read byte not duplicated");
  AST_NO_ACK_DMA: assert property (@(posedge clock) disable iff (!resetn)
    $past(dmaActive) |-> transferAckOut)
    else $error("Acknowledge during DMA");
  AST_ACK_RELEASE: assert property (@(posedge clock) disable iff (!resetn)
    seqAckHeld ##1 (!ackOe_reg || ackOut_reg) |-> $past(!test_output_enable) or
      (ackOe_reg ##1 !ackOe_reg))
    else $error("Acknowledge not released through high");
  AST_ACK_HIGH_THEN_Z: assert property (@(posedge clock) disable iff (!resetn)
    state_reg == hbd_pkg::ST_RELEASE && ackOe_reg |-> seqAckDriveHigh)
    else $error("Acknowledge high drive not followed by release");
  AST_TEST_OE: assert property (@(posedge clock) disable iff (!resetn)
    !test_output_enable |=> !hostDataOe && !transferAckOe && !dmaRequestOe && !clockHalfOe)
    else $error("Pin driven while test enable low");
  AST_CLK_HALF: assert property (@(posedge clock) disable iff (!resetn)
    clockHalf |=> !clockHalf ##1 clockHalf)
    else $error("Half clock not toggling");
  AST_START_QUAL: assert property (@(posedge clock) disable iff (!resetn)
    access.write || access.read |-> $past(ioSelect))
    else $error("Access without select and strobe");
  AST_LOW_BYTE: assert property (@(posedge clock) disable iff (!resetn)
    access.write && !access.dma_buffer_register |-> access.word[15:8] == `HBD_BYTE_ZERO)
    else $error("Upper byte stored on ordinary write");
  AST_REQ_STOP: assert property (@(posedge clock) disable iff (!resetn)
    dmaAckFall && dmaStopAfter |=> dmaRequestOut [*2])
    else $error("Request kept after stop");
  AST_SVC: assert property (@(posedge clock) disable iff (!resetn)
    access.service_acknowledge_n |-> $past(svcSelect))
    else $error("Service acknowledge without grant");

  sequence seqAccessPulse;
    access.write || access.read || access.service_acknowledge_n;
  endsequence

  AST_ACK_AFTER_ACCESS: assert property (@(posedge clock) disable iff (!resetn)
    seqAccessPulse |-> ##2 ((!transferAckOut || $past(dmaActive) || $past(!strobe)) &&
      (transferAckOe || $past(!test_output_enable))))
    else $error("Acknowledge missing after access");
  AST_DMA_DIR_OE: assert property (@(posedge clock) disable iff (!resetn)
    $past(dmaActive) && $past(test_output_enable) |-> hostDataOe == $past(toHost))
    else $error("Data bus drive not following DMA direction");
  AST_DMA_NO_START: assert property (@(posedge clock) disable iff (!resetn)
    dmaActive && state_reg == hbd_pkg::ST_IDLE |=> state_reg == hbd_pkg::ST_IDLE)
    else $error("Register cycle started during DMA");
  AST_REQ_ON: assert property (@(posedge clock) disable iff (!resetn)
    dmaEnableBit && fifoWantsDma && !dmaActive |=> !dmaRequestOut)
    else $error("Request missing while DMA wanted");
  AST_REQ_OFF: assert property (@(posedge clock) disable iff (!resetn)
    !dmaEnableBit |=> dmaRequestOut)
    else $error("Request while DMA disabled");
  AST_DMA_RX_ORDER: assert property (@(posedge clock) disable iff (!resetn)
    dmaAckRise && !toHost |=> dmaWord.valid &&
      orderWord($past(order), dmaWord.first, dmaWord.second) == $past(dmaCapture_reg))
    else $error("Received DMA bytes in wrong order");
  AST_BUF_FULL_WORD: assert property (@(posedge clock) disable iff (!resetn)
    access.write && access.dma_buffer_register |->
      orderWord($past(order), access.word[15:8], access.word[7:0]) == $past(pins_reg.data))
    else $error("DMA buffer write lost bits");
  AST_READ_OE_STROBE: assert property (@(posedge clock) disable iff (!resetn)
    hostDataOe && !$past(dmaActive) |-> $past(strobe) && $past(readCycle_reg))
    else $error("Read data driven without strobe");
  AST_SYNC_TWO: assert property (@(posedge clock) disable iff (!resetn)
    $past(resetn, 2) |-> pins_reg == $past(pinsIn, 2))
    else $error("Pin sampled without two flip-flops");
  AST_OE_ON: assert property (@(posedge clock) disable iff (!resetn)
    test_output_enable |=> clockHalfOe && dmaRequestOe)
    else $error("Output not enabled with test enable high");
  AST_DMA_TAKEN: assert property (@(posedge clock) disable iff (!resetn)
    dmaAckRise && toHost |=> dmaWordTaken && !dmaWord.valid)
    else $error("Word to host not reported taken");

endmodule

//--- verification/hbd_dma_partner.sv
// DMA controller model: acknowledges only a pending request.
// Assumes the bench keeps chip select high while it runs.
`timescale 1ns/1ps
module hbd_dma_partner (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Control from bench
  input wire logic go,
  // DMA handshake
  input wire logic dmaRequestOut,
  output logic dmaAcknowledgeN,
  output logic [3:0] doneCount
);
  logic [3:0] phaseReg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phaseReg <= 4'h0;
      dmaAcknowledgeN <= 1'b1;
      doneCount <= 4'h0;
    end else if (phaseReg == 4'h0) begin
      if (go && !dmaRequestOut) begin
        phaseReg <= 4'h1;
        dmaAcknowledgeN <= 1'b0;
      end
    end else begin
      // Long ack covers the synchroniser; wrap gives idle spacing
      phaseReg <= phaseReg + 4'h1;
      if (phaseReg == 4'h6) begin
        dmaAcknowledgeN <= 1'b1;
        doneCount <= doneCount + 4'h1;
      end
    end
  end
endmodule

//--- verification/host_bus_dma_interface_test.sv
// Bench for the host port: host register cycles and DMA through the partner.
// Assumes the rtl package and header are compiled first.
`timescale 1ns/1ps
`include "hbd_params.svh"
module host_bus_dma_interface_test;
  logic clock = 0;
  logic resetn = 0;
  logic [6:0] addr = 7'h00;
  logic [15:0] din = 16'h0000;
  logic csN = 1, dsN = 1, rwN = 1, bos = 1, toe = 1, psaN = 1, dgN = 1;
  logic dEn = 0, dDir = 0, want = 0, stop = 0, go = 0;
  logic [7:0] rd = 8'h00;
  logic [7:0] f1 = 8'h81;
  logic [7:0] f2 = 8'h7e;
  logic [15:0] dout, lastDma, seen;
  logic doe, ackO, ackOe, ch, chOe, reqO, reqOe, ackN, taken, reqUp, ackBad, takenSeen;
  logic clr = 0;
  logic [3:0] done, goal;
  hbd_pkg::hbd_access_s acc, lastAcc;
  hbd_pkg::hbd_dma_s dw;
  int badCount = 0;
  int nChecks = 0;

  initial forever #4 clock = ~clock;

  hbd_host_port i_dut (.clock(clock), .resetn(resetn), .hostAddress(addr),
    .hostDataIn(din), .hostDataOut(dout), .hostDataOe(doe), .chipSelectN(csN),
    .dataStrobeN(dsN), .readWriteN(rwN), .byteOrderSelect(bos),
    .testOutputEnable(toe), .transferAckOut(ackO), .transferAckOe(ackOe),
    .clockHalf(ch), .clockHalfOe(chOe), .dmaRequestOut(reqO), .dmaRequestOe(reqOe),
    .dmaAcknowledgeN(ackN), .portServiceAcknowledgeN(psaN), .daisyGrantN(dgN),
    .access(acc), .regReadData(rd), .dmaEnableBit(dEn), .dmaDirectionBit(dDir),
    .fifoWantsDma(want), .dmaStopAfter(stop), .dmaFirstByte(f1),
    .dmaSecondByte(f2), .dmaWord(dw), .dmaWordTaken(taken));

  hbd_dma_partner i_partner (.clock(clock), .resetn(resetn), .go(go),
    .dmaRequestOut(reqO), .dmaAcknowledgeN(ackN), .doneCount(done));

  // Monitor flags have this one writer; tasks empty them through clr
  always @(posedge clock) begin
    if (dw.valid) lastDma <= {dw.first, dw.second};
    if (!ackN && doe) lastDma <= dout;
    if (clr) begin
      {lastAcc, reqUp, ackBad, takenSeen} <= '0;
    end else begin
      if (acc.write || acc.read || acc.service_acknowledge_n) lastAcc <= acc;
      if (!ackN && reqO) reqUp <= 1'b1;
      if (!ackN && ackOe && !ackO) ackBad <= 1'b1;
      if (taken) takenSeen <= 1'b1;
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    nChecks++;
    if (g !== e) begin
      badCount++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  function automatic logic cond(input int k);
    case (k)
      0: return ackOe & !ackO;
      default: return done == goal;
    endcase
  endfunction

  task automatic waitFor(input int k);
    int i;
    for (i = 0; i < 60 && cond(k) !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (i == 60) begin
      badCount++;
      tally_and_finish();
    end
  endtask

  task automatic cyc(input logic svc, input logic w, input logic [6:0] a,
                     input logic [15:0] d);
    int i;
    logic prevAck;
    @(negedge clock);
    clr = 1;
    @(negedge clock);
    clr = 0;
    {addr, din, rwN, csN, dgN, psaN} = {a, d, !w, svc, !svc, !svc};
    dsN = 0;
    waitFor(0);
    seen = doe ? dout : 16'hxxxx;
    @(negedge clock);
    {dsN, csN, dgN, psaN} = 4'hf;
    prevAck = 1'b0;
    for (i = 0; i < 20 && ackOe; i++) begin
      prevAck = ackO;
      @(posedge clock);
      #1;
    end
    chk("ack released", 16'h0000, ackOe);
    chk("ack driven high", 16'h0001, prevAck);
    repeat (2) @(negedge clock);
  endtask

  task automatic t_reset();
    logic c;
    chk("oe at reset", 16'h0003, {doe, ackOe, ackO, reqO});
    @(negedge clock);
    resetn = 1;
    repeat (5) @(posedge clock);
    #1;
    c = ch;
    @(posedge clock);
    #1;
    chk("half clock", !c, ch);
    $display("test reset done");
  endtask

  task automatic t_write();
    cyc(0, 1, 7'h05, 16'ha5c3);
    chk("write word", 16'h00c3, lastAcc.word);
    chk("write flags", 16'h0105, {lastAcc.write, lastAcc.dma_buffer_register, lastAcc.addr});
    cyc(0, 1, `HBD_DMA_BUF_ADDR, 16'h1234);
    chk("buf word hi", 16'h1234, lastAcc.word);
    bos = 0;
    cyc(0, 1, `HBD_DMA_BUF_ADDR, 16'h1234);
    chk("buf word lo", 16'h3412, lastAcc.word);
    chk("buf flag", 16'h0001, lastAcc.dma_buffer_register);
    bos = 1;
    $display("test write done");
  endtask

  task automatic t_read();
    rd = 8'h5a;
    cyc(0, 0, 7'h11, 16'h0000);
    chk("read bus", 16'h5a5a, seen);
    chk("read flag", 16'h0001, lastAcc.read);
    cyc(1, 0, 7'h22, 16'h0000);
    chk("svc flag", 16'h0001, lastAcc.service_acknowledge_n);
    @(negedge clock);
    clr = 1;
    @(negedge clock);
    clr = 0;
    dsN = 0;
    repeat (10) @(posedge clock);
    #1;
    chk("no select", 16'h0000, {ackOe, lastAcc.read, lastAcc.write});
    @(negedge clock);
    dsN = 1;
    $display("test read done");
  endtask

  task automatic t_dma(input logic dir, input logic order, input logic stp);
    logic [15:0] e;
    @(negedge clock);
    {dDir, bos, stop, dEn, want, din} = {dir, order, stp, 2'b11, 16'hc33c};
    clr = 1;
    repeat (4) @(posedge clock);
    #1;
    chk("request low", 16'h0000, reqO);
    @(negedge clock);
    {clr, goal, go, dsN, rwN} = {1'b0, done + 4'h1, 1'b1, 2'b00};
    waitFor(1);
    @(negedge clock);
    {go, want, dsN, rwN} = 4'b0011;
    repeat (6) @(posedge clock);
    #1;
    if (dir) e = order ? {f1, f2} : {f2, f1};
    else e = order ? 16'hc33c : 16'h3cc3;
    chk("dma word", e, lastDma);
    chk("stop drop", stp, reqUp);
    chk("no ack in dma", 16'h0000, ackBad);
    chk("word taken", dir, takenSeen);
    $display("test dma done");
  endtask

  task automatic t_toe();
    @(negedge clock);
    toe = 0;
    repeat (5) @(posedge clock);
    #1;
    chk("tristate", 16'h0000, {doe, ackOe, chOe, reqOe});
    @(negedge clock);
    toe = 1;
    repeat (5) @(posedge clock);
    #1;
    chk("outputs on", 16'h0003, {chOe, reqOe});
    $display("test enable done");
  endtask

  initial begin
    repeat (8) @(posedge clock);
    t_reset();
    t_write();
    t_read();
    t_dma(1, 1, 0);
    t_dma(1, 0, 1);
    t_dma(0, 1, 1);
    t_dma(0, 0, 0);
    t_toe();
    tally_and_finish();
  end
endmodule
